// [hw/bsp_ctl_end.sv]
// Memory controller end: makes the link clock and runs one burst at a time.
`timescale 1ns/1ps
module bsp_ctl_end #(
    parameter int DATA_W = bsp_pkg::DATA_W,
    parameter int ADDR_W = bsp_pkg::ADDR_W,
    parameter int LANES = bsp_pkg::LANES
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [DATA_W-1:0] req_wdata0_i,
    input wire logic [DATA_W-1:0] req_wdata1_i,
    input wire logic [LANES-1:0] req_sel0_n_i,
    input wire logic [LANES-1:0] req_sel1_n_i,
    output logic req_ready_o,
    output logic [DATA_W-1:0] rd_word0_o,
    output logic [DATA_W-1:0] rd_word1_o,
    output logic rd_valid_o,
    bsp_link_if.ctl link
);
    import bsp_pkg::*;

    // ====================================================================
    // Link clock divider
    // ====================================================================
    logic [1:0] ph;
    logic [1:0] next_ph;

    assign next_ph = ph + 2'h1;

    // Link clock is high in phases 0 and 1; pins move only in odd phases.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            ph <= PH_RESET;
            link.k <= 1'b0;
            link.kn <= 1'b1;
        end
        else
        begin
            ph <= next_ph;
            link.k <= !next_ph[1];
            link.kn <= next_ph[1];
        end
    end

    // ====================================================================
    // Operation sequencer
    // ====================================================================
    bsp_ctl_state_t st;
    logic [3:0] step;
    logic accept;
    logic [DATA_W-1:0] wd1_keep;
    logic [LANES-1:0] ws1_keep;
    logic rd_done;

    assign req_ready_o = (st == ST_IDLE) && (ph == PH_ISSUE);
    assign accept = req_valid_i && req_ready_o;

    // State and step count.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            st <= ST_IDLE;
            step <= '0;
        end
        else
        begin
            case (st)
                ST_IDLE:
                begin
                    step <= '0;
                    if (accept)
                    begin
                        st <= req_write_i ? ST_WRITE : ST_READ;
                    end
                end
                ST_WRITE:
                begin
                    step <= step + 4'h1;
                    if (step == STEP_WR_END)
                    begin
                        st <= ST_IDLE;
                    end
                end
                ST_READ:
                begin
                    step <= step + 4'h1;
                    // A device that never answers must not hang the port.
                    if (rd_done || step == STEP_RD_MAX)
                    begin
                        st <= ST_IDLE;
                    end
                end
                default:
                begin
                    st <= ST_IDLE;
                    step <= '0;
                end
            endcase
        end
    end

    // Command pins: load is held low across one positive link edge only.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            link.op_load_strobe_n <= 1'b1;
            link.rd_wr_sel <= 1'b1;
            link.addr <= '0;
        end
        else if (accept)
        begin
            link.op_load_strobe_n <= 1'b0;
            link.rd_wr_sel <= !req_write_i;
            link.addr <= req_addr_i;
        end
        else if (st != ST_IDLE && step == STEP_LD_END)
        begin
            link.op_load_strobe_n <= 1'b1;
        end
    end

    // Write data: first word for the next positive edge, second for the
    // negative one; the bus is released when the burst is taken.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            link.ctl_dq <= '0;
            link.ctl_dq_oe <= 1'b0;
            link.lane_sel_n <= '1;
            wd1_keep <= '0;
            ws1_keep <= '1;
        end
        else if (accept && req_write_i)
        begin
            link.ctl_dq <= req_wdata0_i;
            link.lane_sel_n <= req_sel0_n_i;
            wd1_keep <= req_wdata1_i;
            ws1_keep <= req_sel1_n_i;
        end
        else if (st == ST_WRITE && step == STEP_WD0)
        begin
            link.ctl_dq_oe <= 1'b1;
        end
        else if (st == ST_WRITE && step == STEP_WD1)
        begin
            link.ctl_dq <= wd1_keep;
            link.lane_sel_n <= ws1_keep;
        end
        else if (st == ST_WRITE && step == STEP_WR_END)
        begin
            link.ctl_dq_oe <= 1'b0;
            link.lane_sel_n <= '1;
        end
    end

    // ====================================================================
    // Read return
    // ====================================================================
    logic v_s1;
    logic v_s2;
    logic v_s3;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
    logic [1:0] rise_sh;

    // The device answers on its own clock edges, so both pass two stages.
    always_ff @(posedge clk_sys_i)
    begin
        v_s1 <= link.read_valid_flag;
        v_s2 <= v_s1;
        dq_s1 <= link.dq;
        dq_s2 <= dq_s1;
    end

    // Each word sits for two system cycles; take one at the rise of valid
    // and the other two cycles later.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            v_s3 <= 1'b0;
            rise_sh <= '0;
            rd_word0_o <= '0;
            rd_word1_o <= '0;
            rd_valid_o <= 1'b0;
        end
        else
        begin
            v_s3 <= v_s2;
            rise_sh <= {rise_sh[0], st == ST_READ && v_s2 && !v_s3};
            rd_valid_o <= rd_done;
            if (st == ST_READ && v_s2 && !v_s3)
            begin
                rd_word0_o <= dq_s2;
            end
            if (rd_done)
            begin
                rd_word1_o <= dq_s2;
            end
        end
    end

    assign rd_done = (st == ST_READ) && rise_sh[1];

endmodule // bsp_ctl_end

// [hw/bsp_dev_end.sv]
// Memory device end: command capture, two-word bursts, echo clocks.
//
// Notes on behaviour
// - Controller pulls load low to start operation.
// - Every operation moves exactly two words.
// - Narrow variant: nibble selects gate data halves.
// - Lane selects sampled with their data word.
// - Deselected lanes are ignored and keep contents.
// - Wide variants: nine-bit lanes per byte select.
// - Address captured on positive clock at load.
// - Address ignored on cycles without load.
// - Storage is two half-depth arrays, word pairs.
// - Read/write select high reads, low writes.
// - Read-valid frames read data, aligned to echo.
// - Accesses start only on positive clock rise.
// - Second write word captured on negative clock.
// - Echo clocks run freely, follow input clock.
// - Read data on both clocks, else released.
`timescale 1ns/1ps
module bsp_dev_end #(
    parameter int DATA_W = bsp_pkg::DATA_W,
    parameter int LANE_W = bsp_pkg::LANE_W,
    parameter int ADDR_W = bsp_pkg::ADDR_W,
    parameter int DEPTH = bsp_pkg::ARRAY_DEPTH
) (
    bsp_link_if.dev link,
    input wire logic rstn_i
);
    import bsp_pkg::*;

    localparam int LN = DATA_W / LANE_W;

    // ====================================================================
    // Command capture on the positive clock
    // ====================================================================
    logic load;
    logic rd_p1;
    logic rd_p2;
    logic rd_p3;
    logic wr_p1;
    logic wr_p2;
    logic [ADDR_W-1:0] rd_addr;
    logic [ADDR_W-1:0] wr_addr;
    logic [ADDR_W-1:0] wr_addr2;

    // A load with the strobe high is simply absent; work in flight goes on.
    assign load = !link.op_load_strobe_n;

    // Read pipeline: one stage per positive edge, three edges deep.
    always_ff @(posedge link.k)
    begin
        if (!rstn_i)
        begin
            rd_p1 <= 1'b0;
            rd_p2 <= 1'b0;
            rd_p3 <= 1'b0;
        end
        else
        begin
            rd_p1 <= load && link.rd_wr_sel;
            rd_p2 <= rd_p1;
            rd_p3 <= rd_p2;
        end
    end

    // Write pipeline: load, first word, commit.
    always_ff @(posedge link.k)
    begin
        if (!rstn_i)
        begin
            wr_p1 <= 1'b0;
            wr_p2 <= 1'b0;
        end
        else
        begin
            wr_p1 <= load && !link.rd_wr_sel;
            wr_p2 <= wr_p1;
        end
    end

    // The shared address pins are only looked at on a load edge.
    always_ff @(posedge link.k)
    begin
        if (!rstn_i)
        begin
            rd_addr <= '0;
            wr_addr <= '0;
        end
        else if (load)
        begin
            if (link.rd_wr_sel)
            begin
                rd_addr <= link.addr;
            end
            else
            begin
                wr_addr <= link.addr;
            end
        end
    end

    // Keep the write address with the data so a new load cannot disturb it.
    always_ff @(posedge link.k)
    begin
        if (!rstn_i)
        begin
            wr_addr2 <= '0;
        end
        else
        begin
            wr_addr2 <= wr_addr;
        end
    end

    // ====================================================================
    // Write data capture on both clocks
    // ====================================================================
    logic [DATA_W-1:0] wd0;
    logic [DATA_W-1:0] wd1;
    logic [LN-1:0] ws0_n;
    logic [LN-1:0] ws1_n;

    // First word and its lane selects on the positive edge after the load.
    always_ff @(posedge link.k)
    begin
        if (!rstn_i)
        begin
            wd0 <= '0;
            ws0_n <= '1;
        end
        else if (wr_p1)
        begin
            wd0 <= link.dq;
            ws0_n <= link.lane_sel_n;
        end
    end

    // Second word on the negative clock, half a cycle later.
    always_ff @(posedge link.kn)
    begin
        if (!rstn_i)
        begin
            wd1 <= '0;
            ws1_n <= '1;
        end
        else if (wr_p2)
        begin
            wd1 <= link.dq;
            ws1_n <= link.lane_sel_n;
        end
    end

    // ====================================================================
    // Two half-depth arrays, one per burst word
    // ====================================================================
    logic [DATA_W-1:0] rdata0;
    logic [DATA_W-1:0] rdata1;

    // Each address picks one word from each array, so a burst is a pair.
    bsp_store #(
        .DATA_W(DATA_W),
        .LANE_W(LANE_W),
        .ADDR_W(ADDR_W),
        .DEPTH(DEPTH)
    ) u_array0 (
        .clk_i(link.k),
        .we_i(wr_p2),
        .waddr_i(wr_addr2),
        .wdata_i(wd0),
        .wsel_n_i(ws0_n),
        .raddr_i(rd_addr),
        .rdata_o(rdata0)
    );

    bsp_store #(
        .DATA_W(DATA_W),
        .LANE_W(LANE_W),
        .ADDR_W(ADDR_W),
        .DEPTH(DEPTH)
    ) u_array1 (
        .clk_i(link.k),
        .we_i(wr_p2),
        .waddr_i(wr_addr2),
        .wdata_i(wd1),
        .wsel_n_i(ws1_n),
        .raddr_i(rd_addr),
        .rdata_o(rdata1)
    );

    // ====================================================================
    // Read output, double rate
    // ====================================================================
    logic [DATA_W-1:0] hold0;
    logic [DATA_W-1:0] hold1;
    logic [DATA_W-1:0] q_k;
    logic [DATA_W-1:0] q_kn;
    logic v_k;
    logic v_kn;

    // Hold both words: a back-to-back read refreshes the arrays next edge.
    always_ff @(posedge link.k)
    begin
        if (!rstn_i)
        begin
            hold0 <= '0;
            hold1 <= '0;
        end
        else if (rd_p2)
        begin
            hold0 <= rdata0;
            hold1 <= rdata1;
        end
    end

    // First word leaves on the negative clock two and a half cycles on.
    always_ff @(posedge link.kn)
    begin
        if (!rstn_i)
        begin
            q_kn <= '0;
            v_kn <= 1'b0;
        end
        else
        begin
            q_kn <= hold0;
            v_kn <= rd_p3;
        end
    end

    // Second word follows on the next positive edge.
    always_ff @(posedge link.k)
    begin
        if (!rstn_i)
        begin
            q_k <= '0;
            v_k <= 1'b0;
        end
        else
        begin
            q_k <= hold1;
            v_k <= rd_p3;
        end
    end

    // The pin follows whichever clock rose last, as an output DDR cell does;
    // the enable drops as soon as no read word is due.
    assign link.dev_dq = link.k ? q_k : q_kn;
    assign link.read_valid_flag = link.k ? v_k : v_kn;
    assign link.dev_dq_oe = link.k ? v_k : v_kn;

    // ====================================================================
    // Echo clocks
    // ====================================================================
    // Free running even in reset, so the controller can always lock on.
    assign link.echo_timing_p = link.k;
    assign link.echo_timing_n = link.kn;

endmodule // bsp_dev_end

// [hw/bsp_link_if.sv]
// Pin-level link between the memory device and its controller.
`timescale 1ns/1ps
interface bsp_link_if #(
    parameter int DATA_W = bsp_pkg::DATA_W,
    parameter int ADDR_W = bsp_pkg::ADDR_W,
    parameter int LANES = bsp_pkg::LANES
);
    logic k;
    logic kn;
    logic op_load_strobe_n;
    logic rd_wr_sel;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lane_sel_n;
    logic [DATA_W-1:0] ctl_dq;
    logic ctl_dq_oe;
    logic [DATA_W-1:0] dev_dq;
    logic dev_dq_oe;
    logic read_valid_flag;
    logic echo_timing_p;
    logic echo_timing_n;
    logic [DATA_W-1:0] dq;

    // ====================================================================
    // Shared data wire
    // ====================================================================
    // The device wins when both drive; the controller never does so.
    assign dq = dev_dq_oe ? dev_dq : ctl_dq;

    modport dev (
        input k, kn, op_load_strobe_n, rd_wr_sel, addr, lane_sel_n, dq,
        output dev_dq, dev_dq_oe, read_valid_flag, echo_timing_p, echo_timing_n
    );
    modport ctl (
        output k, kn, op_load_strobe_n, rd_wr_sel, addr, lane_sel_n, ctl_dq, ctl_dq_oe,
        input dq, read_valid_flag, echo_timing_p, echo_timing_n
    );
endinterface // bsp_link_if

// [hw/bsp_pkg.sv]
// Shared constants and types for the two-word burst memory port.
package bsp_pkg;

    // =====================================================================
    // Geometry
    // =====================================================================
    localparam int DATA_W = 8;
    localparam int LANE_W = 4;
    localparam int LANES = DATA_W / LANE_W;
    localparam int ADDR_W = 20;
    localparam int ARRAY_DEPTH = 1 << ADDR_W;

    // =====================================================================
    // Timing
    // =====================================================================
    // System clock period and the divider that makes the link clock.
    localparam int SYS_PERIOD_PS = 8000;
    localparam int K_DIV = 4;
    localparam int K_PERIOD_PS = SYS_PERIOD_PS * K_DIV;
    // Phase in which a request is taken; the pins then change as phase 3
    // begins, half way between link clock edges, so none moves at a k rise.
    localparam logic [1:0] PH_ISSUE = 2'h2;
    localparam logic [1:0] PH_RESET = 2'h3;
    // Controller step counts, in system cycles after the issue edge.
    localparam logic [3:0] STEP_LD_END = 4'h1;
    localparam logic [3:0] STEP_WD0 = 4'h3;
    localparam logic [3:0] STEP_WD1 = 4'h5;
    localparam logic [3:0] STEP_WR_END = 4'h7;
    localparam logic [3:0] STEP_RD_MAX = 4'hf;

    // =====================================================================
    // Controller states
    // =====================================================================
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ = 3'b100
    } bsp_ctl_state_t;

endpackage

// [hw/bsp_store.sv]
// One half-depth storage array with lane-gated writes.
`timescale 1ns/1ps
module bsp_store #(
    parameter int DATA_W = bsp_pkg::DATA_W,
    parameter int LANE_W = bsp_pkg::LANE_W,
    parameter int ADDR_W = bsp_pkg::ADDR_W,
    parameter int DEPTH = bsp_pkg::ARRAY_DEPTH
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] waddr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic [DATA_W/LANE_W-1:0] wsel_n_i,
    input wire logic [ADDR_W-1:0] raddr_i,
    output logic [DATA_W-1:0] rdata_o
);
    import bsp_pkg::*;

    logic [DATA_W-1:0] mem [DEPTH];

    // ====================================================================
    // Write and read ports
    // ====================================================================
    // Deselected lanes keep their old contents.
    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < DATA_W / LANE_W; i++)
        begin
            if (we_i && !wsel_n_i[i])
            begin
                mem[waddr_i][i*LANE_W +: LANE_W] <= wdata_i[i*LANE_W +: LANE_W];
            end
        end
    end

    // Registered read; contents are not reset, like a real array.
    always_ff @(posedge clk_i)
    begin
        rdata_o <= mem[raddr_i];
    end
endmodule // bsp_store

// [test/bsp_link_properties.sv]
// Concurrent checks on the pins between the memory device and its controller.
`timescale 1ns/1ps
module bsp_link_properties
    import bsp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic k,
    input wire logic kn,
    input wire logic op_load_strobe_n,
    input wire logic rd_wr_sel,
    input wire logic [bsp_pkg::LANES-1:0] lane_sel_n,
    input wire logic ctl_dq_oe,
    input wire logic dev_dq_oe,
    input wire logic read_valid_flag,
    input wire logic echo_timing_p,
    input wire logic echo_timing_n
);
    // =====================================================================
    // Clocks
    // =====================================================================
    // Echo clocks are sampled on the system clock because they move with k itself.
    AST_ECHO_FOLLOWS: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        echo_timing_p == k && echo_timing_n == kn) else $error("echo clocks off input clocks");
    AST_ECHO_COMPLEMENT: assert property (@(posedge k) disable iff (!rstn_i)
        echo_timing_n != echo_timing_p) else $error("echo pair not complementary");
    AST_K_PERIOD: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        $rose(k) |-> ##2 $fell(k) ##2 $rose(k)) else $error("link clock period wrong");

    // =====================================================================
    // Commands and bursts
    // =====================================================================
    AST_LOAD_ONE_CYCLE: assert property (@(posedge k) disable iff (!rstn_i)
        !op_load_strobe_n |=> op_load_strobe_n) else $error("load held over two cycles");
    AST_READ_LATENCY: assert property (@(posedge k) disable iff (!rstn_i)
        (!op_load_strobe_n && rd_wr_sel) |-> ##2 !read_valid_flag ##1 read_valid_flag
        ##1 !read_valid_flag) else $error("read valid window misplaced");
    // A late driver would fight the controller on the shared data wire.
    AST_DRIVE_ONLY_READ: assert property (@(posedge k) disable iff (!rstn_i)
        dev_dq_oe |-> $past(!op_load_strobe_n && rd_wr_sel, 3)) else $error("device drove dq");
    AST_WRITE_TWO_WORDS: assert property (@(posedge k) disable iff (!rstn_i)
        (!op_load_strobe_n && !rd_wr_sel) |-> ##1 ctl_dq_oe ##1 !ctl_dq_oe)
        else $error("write burst length wrong");
    AST_VALID_ALIGN: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        $changed(read_valid_flag) |-> $changed(k)) else $error("read valid off clock edge");

    // =====================================================================
    // Coverage
    // =====================================================================
    COV_READ: cover property (@(posedge k) $rose(read_valid_flag));
    COV_WRITE: cover property (@(posedge k) !op_load_strobe_n && !rd_wr_sel);
    COV_MASKED: cover property (@(posedge k) ctl_dq_oe && lane_sel_n != '1);
endmodule // bsp_link_properties

// [test/burst2_sram_port_tb.sv]
// Self-checking bench joining controller and device ends across the link.
`timescale 1ns/1ps
module burst2_sram_port_tb;
    import bsp_pkg::*;
    localparam int AW = 10;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic dev_rstn = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [AW-1:0] req_addr = '0;
    logic [DATA_W-1:0] wd0 = '0;
    logic [DATA_W-1:0] wd1 = '0;
    logic [LANES-1:0] sel0 = '1;
    logic [LANES-1:0] sel1 = '1;
    logic req_ready;
    logic [DATA_W-1:0] rw0;
    logic [DATA_W-1:0] rw1;
    logic rd_valid;
    logic [DATA_W-1:0] r0;
    logic [DATA_W-1:0] r1;
    logic [AW-1:0] addrs [4] = '{10'h000, 10'h001, 10'h155, 10'h3ff};
    int errors = 0;
    int num_checks = 0;

    // =====================================================================
    // Clock and ends
    // =====================================================================
    // System clock at 125 MHz; the link clock comes from the controller.
    always #4 clk_sys = ~clk_sys;

    bsp_link_if #(.ADDR_W(AW)) link ();
    bsp_ctl_end #(.ADDR_W(AW)) i_bsp_ctl_end (.clk_sys_i(clk_sys), .rstn_i(rstn),
        .req_valid_i(req_valid), .req_write_i(req_write), .req_addr_i(req_addr),
        .req_wdata0_i(wd0), .req_wdata1_i(wd1), .req_sel0_n_i(sel0), .req_sel1_n_i(sel1),
        .req_ready_o(req_ready), .rd_word0_o(rw0), .rd_word1_o(rw1), .rd_valid_o(rd_valid),
        .link(link));
    // Small depth keeps the simulator's memory footprint low.
    bsp_dev_end #(.ADDR_W(AW), .DEPTH(1 << AW)) i_bsp_dev_end (.link(link), .rstn_i(dev_rstn));
    bsp_link_properties i_bsp_link_properties (.clk_sys_i(clk_sys), .rstn_i(dev_rstn),
        .k(link.k), .kn(link.kn), .op_load_strobe_n(link.op_load_strobe_n),
        .rd_wr_sel(link.rd_wr_sel), .lane_sel_n(link.lane_sel_n), .ctl_dq_oe(link.ctl_dq_oe),
        .dev_dq_oe(link.dev_dq_oe), .read_valid_flag(link.read_valid_flag),
        .echo_timing_p(link.echo_timing_p), .echo_timing_n(link.echo_timing_n));

    // =====================================================================
    // Tasks
    // =====================================================================
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // The device only leaves reset on k edges, so the controller must run first.
    task automatic do_reset();
        @(posedge clk_sys);
        #1;
        rstn = 1'b0;
        dev_rstn = 1'b0;
        repeat (16) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        repeat (16) @(posedge clk_sys);
        #1;
        dev_rstn = 1'b1;
    endtask

    // Hold the request until an edge sees ready high, then drop it.
    task automatic issue(input logic wr, input logic [AW-1:0] a, input logic [DATA_W-1:0] d0,
                         input logic [DATA_W-1:0] d1, input logic [LANES-1:0] s0,
                         input logic [LANES-1:0] s1);
        int n;
        n = 0;
        @(posedge clk_sys);
        #1;
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        wd0 = d0;
        wd1 = d1;
        sel0 = s0;
        sel1 = s1;
        while (req_ready !== 1'b1 && n < 40)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 40)
            check(8'h00, 8'h01);
        @(posedge clk_sys);
        #1;
        req_valid = 1'b0;
    endtask

    task automatic do_write(input logic [AW-1:0] a, input logic [DATA_W-1:0] d0,
                            input logic [DATA_W-1:0] d1, input logic [LANES-1:0] s0,
                            input logic [LANES-1:0] s1);
        issue(1'b1, a, d0, d1, s0, s1);
    endtask

    task automatic do_read(input logic [AW-1:0] a, output logic [DATA_W-1:0] d0,
                           output logic [DATA_W-1:0] d1);
        int n;
        n = 0;
        issue(1'b0, a, '0, '0, '1, '1);
        while (rd_valid !== 1'b1 && n < 40)
        begin
            @(negedge clk_sys);
            n++;
        end
        d0 = rw0;
        d1 = rw1;
        @(negedge clk_sys);
        check({7'h00, rd_valid}, 8'h00);
    endtask

    // Lanes whose select is high keep the old contents.
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_w,
                                               input logic [DATA_W-1:0] new_w,
                                               input logic [LANES-1:0] sel_n);
        logic [DATA_W-1:0] r;
        r = old_w;
        for (int i = 0; i < LANES; i++)
            if (!sel_n[i]) r[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
        return r;
    endfunction

    // =====================================================================
    // Tests
    // =====================================================================
    // Main sequence; every test prints one line as it ends.
    initial
    begin
        do_reset();
        // Distinct pairs at edge addresses, read back in reverse order.
        for (int i = 0; i < 4; i++)
            do_write(addrs[i], 8'(8'h21 * (i + 1)), ~8'(8'h21 * (i + 1)), '0, '0);
        for (int i = 3; i >= 0; i--)
        begin
            do_read(addrs[i], r0, r1);
            check(r0, 8'(8'h21 * (i + 1)));
            check(r1, ~8'(8'h21 * (i + 1)));
        end
        $display("test pairs done");
        // Every lane mask, with different masks on the two words.
        for (int m = 0; m < 4; m++)
        begin
            do_write(10'h020 + AW'(m), 8'h00, 8'hff, '0, '0);
            do_write(10'h020 + AW'(m), 8'ha5, 8'h3c, LANES'(m), ~LANES'(m));
            do_read(10'h020 + AW'(m), r0, r1);
            check(r0, merge(8'h00, 8'ha5, LANES'(m)));
            check(r1, merge(8'hff, 8'h3c, ~LANES'(m)));
        end
        $display("test lanes done");
        // Read right after a write, then again after a long idle stretch.
        do_write(10'h2aa, 8'hc3, 8'h96, '0, '0);
        do_read(10'h2aa, r0, r1);
        check(r0, 8'hc3);
        check(r1, 8'h96);
        repeat (50) @(posedge clk_sys);
        do_read(10'h2aa, r0, r1);
        check(r0, 8'hc3);
        check(r1, 8'h96);
        $display("test idle done");
        // A second reset keeps the stored words and quiets the outputs.
        fork
            do_reset();
            begin
                repeat (8) @(negedge clk_sys);
                check({7'h00, rd_valid}, 8'h00);
                check({7'h00, req_ready}, 8'h00);
            end
        join
        do_read(addrs[3], r0, r1);
        check(r0, 8'(8'h21 * 4));
        check(r1, ~8'(8'h21 * 4));
        $display("test reset done");
        give_verdict();
    end

    // Watchdog sized well beyond the few hundred cycles the tests need.
    initial
    begin
        #100us;
        errors++;
        $display("wrong value at %0t: run timed out", $time);
        give_verdict();
    end
endmodule // burst2_sram_port_tb
